// ==== pkg/pgpc_consts.vh ====
// Constants for the six-pin port control block: register indices, widths,
// field masks and reset values.
// Assumes it is included by bare name from every design file that needs it.
`ifndef PGPC_CONSTS_VH
`define PGPC_CONSTS_VH

// Port geometry.
`define PGPC_PINS 6
`define PGPC_PIN_MSB 5
`define PGPC_DATA_W 8
`define PGPC_DATA_MSB 7
`define PGPC_ADDR_W 3
`define PGPC_ADDR_MSB 2

// Register indices on the plain register port.
`define PGPC_REG_DATA 3'h0
`define PGPC_REG_DIR 3'h1
`define PGPC_REG_PULL 3'h2
`define PGPC_REG_SLEW 3'h3
`define PGPC_REG_DRIVE 3'h4
`define PGPC_REG_LEVEL 3'h5
`define PGPC_REG_PADSTAT 3'h6

// Reset values of the six-bit fields.
`define PGPC_RST_DATA 6'h00
`define PGPC_RST_DIR 6'h00
`define PGPC_RST_PULL 6'h00
`define PGPC_RST_SLEW 6'h3F
`define PGPC_RST_DRIVE 6'h00
`define PGPC_RST_PINS 6'h00
`define PGPC_ALL_PINS 6'h3F

// Read word helpers.
`define PGPC_RD_ZERO 8'h00
`define PGPC_PAD_ZERO 2'h0

// Pad status field layout: pull-up in bits 5:0 is not enough room, so the
// pad status register reports pull-down state only.
`define PGPC_DRIVEN_ON_N 1'b0
`define PGPC_DRIVEN_OFF_N 1'b1

`endif

// ==== core/pgpc_pin_sync.v ====
// Two-flip-flop synchroniser for the six port pin levels.
// Assumes pins change with no relation to clk; only the second stage is read.
`timescale 1ns/1ns
`include "pgpc_consts.vh"

module pgpc_pin_sync (
  clk,
  reset,
  pin_async,
  pin_sync
);
  input wire clk;
  input wire reset;
  input wire [`PGPC_PIN_MSB:0] pin_async;
  output wire [`PGPC_PIN_MSB:0] pin_sync;

  reg [`PGPC_PIN_MSB:0] stage1_q;
  reg [`PGPC_PIN_MSB:0] stage2_q;

  // The first stage may go metastable, so only the second stage reads it.
  always @(posedge clk) begin
    if (reset) begin
      stage1_q <= `PGPC_RST_PINS;
      stage2_q <= `PGPC_RST_PINS;
    end else begin
      stage1_q <= pin_async;
      stage2_q <= stage1_q;
    end
  end

  assign pin_sync = stage2_q;

endmodule

// ==== core/pgpc_port.v ====
// Pin control for a six-pin general-purpose port: data latch, direction,
// pull-up, slew limiting and drive strength, with pad control outputs.
// Assumes a same-clock register master and pin levels from the pad ring.
//
// Operation
// - Direction 0 disables driver, reads pin.
// - Direction 1 enables driver, reads latch.
// - Pull-enable bit 1 turns pull-up on; the interrupt pull-down overrides it.
// - Output pins keep pull devices disabled.
// - Pull-down only with pin interrupt configured.
// - Slew bit limits slew; inert for inputs.
// - Drive bit selects strength; inert for inputs.
// - Direction bits readable, writable, steer reads.
// - Data writes latch; outputs drive latched level.
// - Reset clears latch, pins float, no pull-up.
// - Drive bit 0 low, 1 high.
`timescale 1ns/1ns
`include "pgpc_consts.vh"

module pgpc_port (
  clk,
  reset,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  pin_in,
  irq_pin_select,
  irq_edge_rise,
  pin_out,
  pin_oe_n,
  pullup_en,
  pulldown_en,
  slew_limit_en,
  drive_high
);
  input wire clk;
  input wire reset;
  input wire [`PGPC_ADDR_MSB:0] reg_addr;
  input wire [`PGPC_DATA_MSB:0] reg_wdata;
  input wire reg_wr;
  input wire reg_rd;
  output reg [`PGPC_DATA_MSB:0] reg_rdata;
  input wire [`PGPC_PIN_MSB:0] pin_in;
  input wire [`PGPC_PIN_MSB:0] irq_pin_select;
  input wire [`PGPC_PIN_MSB:0] irq_edge_rise;
  output reg [`PGPC_PIN_MSB:0] pin_out;
  output reg [`PGPC_PIN_MSB:0] pin_oe_n;
  output reg [`PGPC_PIN_MSB:0] pullup_en;
  output reg [`PGPC_PIN_MSB:0] pulldown_en;
  output reg [`PGPC_PIN_MSB:0] slew_limit_en;
  output reg [`PGPC_PIN_MSB:0] drive_high;

  // Slew reset value is a parameter because silicon versions disagree on it.
  parameter [`PGPC_PIN_MSB:0] SLEW_RESET = `PGPC_RST_SLEW;

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions.

  // Widens a six-bit field to a bus word with the upper bits held at zero.
  function [`PGPC_DATA_MSB:0] pgpc_widen;
    input [`PGPC_PIN_MSB:0] field;
    begin
      pgpc_widen = {`PGPC_PAD_ZERO, field};
    end
  endfunction

  // Takes the six pin bits of a bus word; upper bits are dropped.
  function [`PGPC_PIN_MSB:0] pgpc_field;
    input [`PGPC_DATA_MSB:0] word;
    begin
      pgpc_field = word[`PGPC_PIN_MSB:0];
    end
  endfunction

  // Per-pin select: latch where driven as output, live pin elsewhere.
  function [`PGPC_PIN_MSB:0] pgpc_mux;
    input [`PGPC_PIN_MSB:0] sel;
    input [`PGPC_PIN_MSB:0] when_one;
    input [`PGPC_PIN_MSB:0] when_zero;
    begin
      pgpc_mux = (sel & when_one) | (~sel & when_zero);
    end
  endfunction

  // Write strobe decode for one register index.
  function pgpc_hit;
    input strobe;
    input [`PGPC_ADDR_MSB:0] addr;
    input [`PGPC_ADDR_MSB:0] index;
    begin
      pgpc_hit = strobe && (addr == index);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser.

  wire [`PGPC_PIN_MSB:0] pin_level;

  pgpc_pin_sync u_sync (
    .clk(clk),
    .reset(reset),
    .pin_async(pin_in),
    .pin_sync(pin_level)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Control registers.

  reg [`PGPC_PIN_MSB:0] port_data_latch_q;
  reg [`PGPC_PIN_MSB:0] port_data_latch_d;
  reg [`PGPC_PIN_MSB:0] pin_direction_bits_q;
  reg [`PGPC_PIN_MSB:0] pin_direction_bits_d;
  reg [`PGPC_PIN_MSB:0] pullup_enable_bits_q;
  reg [`PGPC_PIN_MSB:0] pullup_enable_bits_d;
  reg [`PGPC_PIN_MSB:0] slew_limit_bits_q;
  reg [`PGPC_PIN_MSB:0] slew_limit_bits_d;
  reg [`PGPC_PIN_MSB:0] drive_strength_bits_q;
  reg [`PGPC_PIN_MSB:0] drive_strength_bits_d;

  wire wr_data;
  wire wr_dir;
  wire wr_pull;
  wire wr_slew;
  wire wr_drive;

  assign wr_data = pgpc_hit(reg_wr, reg_addr, `PGPC_REG_DATA);
  assign wr_dir = pgpc_hit(reg_wr, reg_addr, `PGPC_REG_DIR);
  assign wr_pull = pgpc_hit(reg_wr, reg_addr, `PGPC_REG_PULL);
  assign wr_slew = pgpc_hit(reg_wr, reg_addr, `PGPC_REG_SLEW);
  assign wr_drive = pgpc_hit(reg_wr, reg_addr, `PGPC_REG_DRIVE);

  always @* begin
    port_data_latch_d = port_data_latch_q;
    pin_direction_bits_d = pin_direction_bits_q;
    pullup_enable_bits_d = pullup_enable_bits_q;
    slew_limit_bits_d = slew_limit_bits_q;
    drive_strength_bits_d = drive_strength_bits_q;
    // Every data write is latched, even for pins that are inputs now.
    if (wr_data) begin
      port_data_latch_d = pgpc_field(reg_wdata);
    end
    if (wr_dir) begin
      pin_direction_bits_d = pgpc_field(reg_wdata);
    end
    if (wr_pull) begin
      pullup_enable_bits_d = pgpc_field(reg_wdata);
    end
    if (wr_slew) begin
      slew_limit_bits_d = pgpc_field(reg_wdata);
    end
    if (wr_drive) begin
      drive_strength_bits_d = pgpc_field(reg_wdata);
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      port_data_latch_q <= `PGPC_RST_DATA;
      pin_direction_bits_q <= `PGPC_RST_DIR;
      pullup_enable_bits_q <= `PGPC_RST_PULL;
      slew_limit_bits_q <= SLEW_RESET;
      drive_strength_bits_q <= `PGPC_RST_DRIVE;
    end else begin
      port_data_latch_q <= port_data_latch_d;
      pin_direction_bits_q <= pin_direction_bits_d;
      pullup_enable_bits_q <= pullup_enable_bits_d;
      slew_limit_bits_q <= slew_limit_bits_d;
      drive_strength_bits_q <= drive_strength_bits_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pad control.

  // Pad controls follow the stored settings one clock later, which keeps
  // every pad output on a flip-flop at the cost of one cycle of latency.
  reg [`PGPC_PIN_MSB:0] pin_out_d;
  reg [`PGPC_PIN_MSB:0] pin_oe_n_d;
  reg [`PGPC_PIN_MSB:0] pullup_en_d;
  reg [`PGPC_PIN_MSB:0] pulldown_en_d;
  reg [`PGPC_PIN_MSB:0] slew_limit_en_d;
  reg [`PGPC_PIN_MSB:0] drive_high_d;
  reg [`PGPC_PIN_MSB:0] irq_pull_down;

  always @* begin
    // A pull-down is only wanted by the pin interrupt when it waits for a
    // rising edge on a selected input pin.
    irq_pull_down = irq_pin_select & irq_edge_rise & ~pin_direction_bits_q;
    pin_oe_n_d = ~pin_direction_bits_q;
    pin_out_d = port_data_latch_q & pin_direction_bits_q;
    pullup_en_d = pullup_enable_bits_q & ~pin_direction_bits_q & ~irq_pull_down;
    pulldown_en_d = irq_pull_down;
    slew_limit_en_d = slew_limit_bits_q & pin_direction_bits_q;
    drive_high_d = drive_strength_bits_q & pin_direction_bits_q;
  end

  always @(posedge clk) begin
    if (reset) begin
      pin_out <= `PGPC_RST_PINS;
      pin_oe_n <= `PGPC_ALL_PINS;
      pullup_en <= `PGPC_RST_PINS;
      pulldown_en <= `PGPC_RST_PINS;
      slew_limit_en <= `PGPC_RST_PINS;
      drive_high <= `PGPC_RST_PINS;
    end else begin
      pin_out <= pin_out_d;
      pin_oe_n <= pin_oe_n_d;
      pullup_en <= pullup_en_d;
      pulldown_en <= pulldown_en_d;
      slew_limit_en <= slew_limit_en_d;
      drive_high <= drive_high_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path.

  reg [`PGPC_DATA_MSB:0] rdata_d;
  wire [`PGPC_PIN_MSB:0] data_view;

  // Input pins show the synchronised level; output pins show the latch.
  assign data_view = pgpc_mux(pin_direction_bits_q, port_data_latch_q, pin_level);

  always @* begin
    rdata_d = `PGPC_RD_ZERO;
    if (reg_rd) begin
      case (reg_addr)
        `PGPC_REG_DATA: begin
          rdata_d = pgpc_widen(data_view);
        end
        `PGPC_REG_DIR: begin
          rdata_d = pgpc_widen(pin_direction_bits_q);
        end
        `PGPC_REG_PULL: begin
          rdata_d = pgpc_widen(pullup_enable_bits_q);
        end
        `PGPC_REG_SLEW: begin
          rdata_d = pgpc_widen(slew_limit_bits_q);
        end
        `PGPC_REG_DRIVE: begin
          rdata_d = pgpc_widen(drive_strength_bits_q);
        end
        `PGPC_REG_LEVEL: begin
          rdata_d = pgpc_widen(pin_level);
        end
        `PGPC_REG_PADSTAT: begin
          rdata_d = pgpc_widen(pulldown_en);
        end
        default: begin
          rdata_d = `PGPC_RD_ZERO;
        end
      endcase
    end
  end

  // Read data stand for exactly the cycle after the strobe, zero otherwise.
  always @(posedge clk) begin
    if (reset) begin
      reg_rdata <= `PGPC_RD_ZERO;
    end else begin
      reg_rdata <= rdata_d;
    end
  end

endmodule

// ==== verification/pgpc_port_asserts.sv ====
// Checker for the six-pin port control block, bound to its top module.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
module pgpc_port_asserts (
  input clk,
  input reset,
  input [2:0] reg_addr,
  input [7:0] reg_wdata,
  input reg_wr,
  input reg_rd,
  input [7:0] reg_rdata,
  input [5:0] pin_in,
  input [5:0] irq_pin_select,
  input [5:0] irq_edge_rise,
  input [5:0] pin_out,
  input [5:0] pin_oe_n,
  input [5:0] pullup_en,
  input [5:0] pulldown_en,
  input [5:0] slew_limit_en,
  input [5:0] drive_high
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////////////
  a_oe_dir_write: assert property (reg_wr && reg_addr == 3'h1 |-> ##2
    pin_oe_n == ~$past(reg_wdata[5:0], 2)) else $error("enable does not follow direction");
  a_out_gated: assert property ((pin_out & pin_oe_n) == 6'h00)
    else $error("level shown on an undriven pin");
  a_pull_outputs: assert property (((pullup_en | pulldown_en) & ~pin_oe_n) == 6'h00)
    else $error("pull device on a driven pin");
  a_pulldown_cause: assert property ((pulldown_en & ~$past(irq_pin_select & irq_edge_rise))
    == 6'h00) else $error("pull-down without pin interrupt setup");
  a_slew_inert: assert property ((slew_limit_en & pin_oe_n) == 6'h00)
    else $error("slew limit on an input pin");
  a_drive_inert: assert property ((drive_high & pin_oe_n) == 6'h00)
    else $error("high drive on an input pin");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its cycle");
  a_upper_zero: assert property (reg_rdata[7:6] == 2'h0)
    else $error("upper read bits not zero");
  // Reset itself is the cause here, so this one must not be disabled by it.
  a_reset_pads: assert property (disable iff (1'b0) reset |=> pin_oe_n == 6'h3F &&
    pullup_en == 6'h00 && pin_out == 6'h00) else $error("pads not released by reset");
  c_dir_write: cover property (reg_wr && reg_addr == 3'h1);
  c_read: cover property (reg_rd && reg_addr == 3'h0);
  c_pulldown: cover property (pulldown_en != 6'h00);
endmodule

// ==== verification/pgpc_pins_model.sv ====
// External circuits on the six port pins: a strong source per pin.
// Assumes the pads drive when pin_oe_n is low; an unheld pin wanders.
`timescale 1ns/1ns
module pgpc_pins_model (
  input clk,
  input [5:0] ext_en,
  input [5:0] ext_val,
  input [5:0] pin_out,
  input [5:0] pin_oe_n,
  input [5:0] pullup_en,
  input [5:0] pulldown_en,
  output logic [5:0] pin_level
);
  logic [5:0] float_q = 6'h15;
  // A floating pin toggles so a lucky settled value cannot pass a read.
  always @(posedge clk) float_q <= ~float_q;
  always_comb begin
    for (int i = 0; i < 6; i++)
      pin_level[i] = !pin_oe_n[i] ? pin_out[i] : ext_en[i] ? ext_val[i] :
        pullup_en[i] ? 1'b1 : pulldown_en[i] ? 1'b0 : float_q[i];
  end
endmodule

// ==== verification/testbench.sv ====
// Self-checking bench for the six-pin port control block.
// Assumes the register port answers reads in the cycle after the strobe.
`timescale 1ns/1ns
module testbench;
  logic clk = 0, reset = 1, reg_wr = 0, reg_rd = 0;
  logic [2:0] reg_addr = 0;
  logic [7:0] reg_wdata = 0;
  logic [5:0] irq_pin_select = 0, irq_edge_rise = 0, ext_en = 6'h3F, ext_val = 0;
  wire [7:0] reg_rdata;
  wire [5:0] pin_in, pin_out, pin_oe_n, pullup_en, pulldown_en, slew_limit_en, drive_high;
  int err_count = 0, comparisons = 0, cyc = 0, seed;
  logic [5:0] m [0:4];
  pgpc_port i_pgpc_port (.clk(clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pin_in(pin_in), .irq_pin_select(irq_pin_select), .irq_edge_rise(irq_edge_rise),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pullup_en(pullup_en),
    .pulldown_en(pulldown_en), .slew_limit_en(slew_limit_en), .drive_high(drive_high));
  pgpc_pins_model i_pgpc_pins_model (.clk(clk), .ext_en(ext_en), .ext_val(ext_val),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pullup_en(pullup_en),
    .pulldown_en(pulldown_en), .pin_level(pin_in));
  initial forever #5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      err_count++;
      report_and_stop();
    end
  end
  task automatic cmp(input string what, input logic [7:0] exp, got, mask);
    comparisons++;
    if ((got & mask) !== (exp & mask)) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp & mask, got & mask);
    end
  endtask
  task automatic pad(input string what, input logic [5:0] exp, got);
    cmp(what, {2'h0, exp}, {2'h0, got}, 8'hFF);
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    if (a < 3'h5) m[a] = d[5:0];
  endtask
  task automatic rd(input logic [2:0] a, input logic [5:0] exp, input logic [5:0] k = 6'h3F);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 cmp("reg_rdata", {2'h0, exp}, reg_rdata, {2'h3, k});
  endtask
  task automatic check_all();
    logic [5:0] pd, pu, lvl, det;
    repeat (4) @(posedge clk);
    pd = irq_pin_select & irq_edge_rise & ~m[1];
    pu = m[2] & ~m[1] & ~pd;
    lvl = (m[0] & m[1]) | (ext_val & ext_en & ~m[1]) | (pu & ~ext_en);
    det = m[1] | ext_en | pu | pd;
    #1;
    pad("pin_oe_n", ~m[1], pin_oe_n);
    pad("pin_out", m[0] & m[1], pin_out);
    pad("pullup_en", pu, pullup_en);
    pad("pulldown_en", pd, pulldown_en);
    pad("slew_limit_en", m[3] & m[1], slew_limit_en);
    pad("drive_high", m[4] & m[1], drive_high);
    rd(3'h0, lvl, det);
    rd(3'h1, m[1]);
    rd(3'h2, m[2]);
    rd(3'h3, m[3]);
    rd(3'h4, m[4]);
    rd(3'h5, lvl, det);
    rd(3'h6, pd);
    rd(3'h7, 6'h00);
  endtask
  initial begin
    seed = $urandom(93279);
    m = '{6'h00, 6'h00, 6'h00, 6'h3F, 6'h00};
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    check_all();
    $display("test reset done");
    // Slew bits are set explicitly since their reset default may vary.
    wr(3'h3, 8'h00);
    wr(3'h1, 8'hC5);
    wr(3'h0, 8'hFF);
    wr(3'h7, 8'hFF);
    wr(3'h5, 8'h00);
    check_all();
    $display("test directed done");
    repeat (40) begin
      @(posedge clk);
      irq_pin_select <= 6'($urandom);
      irq_edge_rise <= 6'($urandom);
      ext_en <= 6'($urandom);
      ext_val <= 6'($urandom);
      wr(3'($urandom % 5), 8'($urandom));
      wr(3'($urandom % 5), 8'($urandom));
      check_all();
    end
    $display("test random done");
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    m = '{6'h00, 6'h00, 6'h00, 6'h3F, 6'h00};
    check_all();
    $display("test second reset done");
    report_and_stop();
  end
endmodule
bind pgpc_port pgpc_port_asserts i_pgpc_port_asserts (.clk(clk), .reset(reset),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .pin_in(pin_in), .irq_pin_select(irq_pin_select),
  .irq_edge_rise(irq_edge_rise), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
  .pullup_en(pullup_en), .pulldown_en(pulldown_en), .slew_limit_en(slew_limit_en),
  .drive_high(drive_high));
